// *** rtl/srat_pkg.sv ***
// Constants shared by the receive address translator
package srat_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W   = 32;           // Packet and local address
    localparam int BUS_AW   = 5;            // Register bus byte address
    localparam int NUM_REG  = 6;            // Size/offset registers
    localparam int NUM_RGN  = 3;            // Mapped regions held here
    // ------------------------------------------------------------
    // Register word indices (byte address is four times these)
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_SIZE1   = 3'h0; // rx_region1_size
    localparam logic [2:0] IDX_OFFSET1 = 3'h1; // rx_region1_offset
    localparam logic [2:0] IDX_SIZE2   = 3'h2; // rx_region2_size
    localparam logic [2:0] IDX_OFFSET2 = 3'h3; // rx_region2_offset
    localparam logic [2:0] IDX_SIZE3   = 3'h4; // rx_region3_size
    localparam logic [2:0] IDX_OFFSET3 = 3'h5; // rx_region3_offset
    localparam logic [2:0] IDX_STATUS  = 3'h6; // Translator status
    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int FIELD_LSB = 2;           // Fields occupy 31:2
    localparam logic [31:0] FIELD_MASK = 32'hFFFF_FFFC;
    localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
    localparam logic [15:0] DROP_RESET = 16'h0000;
endpackage

// *** rtl/srat_top.sv ***
// Receive address translator for mapped regions one to three
module srat_top (
    input  wire logic        clk,
    input  wire logic        rstn,
    // Avalon-MM register slave
    input  wire logic [4:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWritedata,
    output logic      [31:0] avsReaddata,
    output logic             avsWaitrequest,
    // Inbound packet address from serial receive path
    input  wire logic        pktValid,
    input  wire logic [31:0] pktAddr,
    output logic             pktReady,
    // Local configuration bus request
    output logic             locValid,
    output logic      [31:0] locAddr,
    output logic      [1:0]  locRegion,
    input  wire logic        locReady,
    // One-cycle pulse when a packet matched no region
    output logic             pktDrop
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [31:0] cfg_q [srat_pkg::NUM_REG];   // Size/offset words
    logic [31:0] cfg_d [srat_pkg::NUM_REG];   // Next values
    logic [31:0] rdata_q;                     // Read data
    logic [31:0] rdata_d;
    logic        wait_q;                      // Waitrequest
    logic        wait_d;
    logic [15:0] dropCnt_q;                   // Unmatched count
    logic [15:0] dropCnt_d;
    logic [1:0]  lastRgn_q;                   // Last region hit
    logic [1:0]  lastRgn_d;
    logic [2:0]  regIdx;                      // Word index
    // ------------------------------------------------------------
    // Translation path state
    // ------------------------------------------------------------
    logic        locValid_q;                  // Request pending
    logic        locValid_d;
    logic [31:0] locAddr_q;                   // Translated address
    logic [31:0] locAddr_d;
    logic [1:0]  locRegion_q;                 // Region used
    logic [1:0]  locRegion_d;
    logic        pktReady_q;                  // Accept window
    logic        pktReady_d;
    logic        drop_q;                      // Miss pulse
    logic        drop_d;
    logic        accept;                      // Packet taken
    logic        hit;                         // Some region passed
    logic [1:0]  hitRgn;                      // Winning region
    logic [31:0] hitAddr;                     // Winning translation

    assign regIdx = avsAddress[4:2];
    assign accept = pktValid && pktReady_q;

    // ------------------------------------------------------------
    // Region match and translation
    // ------------------------------------------------------------
    // Walk from region three down so the lowest passing region
    // is the last to assign and therefore wins.
    always_comb begin
        hit     = 1'b0;
        hitRgn  = 2'h0;
        hitAddr = 32'h0000_0000;
        for (int i = srat_pkg::NUM_RGN - 1; i >= 0; i--) begin
            // Strictly-below size
            if (pktAddr < cfg_q[2*i]) begin
                hit     = 1'b1;
                hitRgn  = 2'(i);
                // Add the matching offset
                hitAddr = pktAddr + cfg_q[2*i+1];
            end
        end
    end

    // ------------------------------------------------------------
    // Local bus request and packet handshake
    // ------------------------------------------------------------
    // One request is held at a time; the packet side only opens
    // while no request is pending, so nothing is ever overwritten.
    always_comb begin
        locValid_d  = locValid_q;
        locAddr_d   = locAddr_q;
        locRegion_d = locRegion_q;
        drop_d      = 1'b0;
        dropCnt_d   = dropCnt_q;
        lastRgn_d   = lastRgn_q;
        // Request consumed by the local bus
        if (locValid_q && locReady) begin
            locValid_d = 1'b0;
        end
        // New packet taken
        if (accept) begin
            if (hit) begin
                // Issue translated address
                locValid_d  = 1'b1;
                locAddr_d   = hitAddr;
                locRegion_d = hitRgn;
                lastRgn_d   = hitRgn;
            end else begin
                // No region: drop, never issue
                drop_d    = 1'b1;
                dropCnt_d = dropCnt_q + 16'h0001;
            end
        end
        pktReady_d = !locValid_d;
    end

    // Registers of the translation path
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            locValid_q  <= 1'b0;
            locAddr_q   <= srat_pkg::CFG_RESET;
            locRegion_q <= 2'h0;
            pktReady_q  <= 1'b0;
            drop_q      <= 1'b0;
            dropCnt_q   <= srat_pkg::DROP_RESET;
            lastRgn_q   <= 2'h0;
        end else begin
            locValid_q  <= locValid_d;
            locAddr_q   <= locAddr_d;
            locRegion_q <= locRegion_d;
            pktReady_q  <= pktReady_d;
            drop_q      <= drop_d;
            dropCnt_q   <= dropCnt_d;
            lastRgn_q   <= lastRgn_d;
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    // Waitrequest idles high and drops for exactly one cycle per
    // request; read data stand at the edge that drops it, and the write lands at the next edge.
    always_comb begin
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        for (int i = 0; i < srat_pkg::NUM_REG; i++) begin
            cfg_d[i] = cfg_q[i];
        end
        if ((avsRead || avsWrite) && wait_q) begin
            // First cycle of a request: fetch and release wait
            wait_d = 1'b0;
            if (regIdx < 3'(srat_pkg::NUM_REG)) begin
                // Low bits already zero in storage
                rdata_d = cfg_q[regIdx];
            end else if (regIdx == srat_pkg::IDX_STATUS) begin
                rdata_d = {dropCnt_q, 12'h000, lastRgn_q,
                           locValid_q, pktReady_q};
            end else begin
                // Unmapped word reads zero
                rdata_d = 32'h0000_0000;
            end
        end else if (avsWrite && !wait_q) begin
            // Completing write: only fields 31:2 are kept
            if (regIdx < 3'(srat_pkg::NUM_REG)) begin
                cfg_d[regIdx] = avsWritedata & srat_pkg::FIELD_MASK;
            end
        end
    end

    // Registers of the slave
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
            for (int i = 0; i < srat_pkg::NUM_REG; i++) begin
                cfg_q[i] <= srat_pkg::CFG_RESET;
            end
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
            for (int i = 0; i < srat_pkg::NUM_REG; i++) begin
                cfg_q[i] <= cfg_d[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avsReaddata    = rdata_q;
    assign avsWaitrequest = wait_q;
    assign pktReady       = pktReady_q;
    assign locValid       = locValid_q;
    assign locAddr        = locAddr_q;
    assign locRegion      = locRegion_q;
    assign pktDrop        = drop_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic below1;                          // Size tests for checks
    logic below2;
    logic below3;
    assign below1 = pktAddr < cfg_q[srat_pkg::IDX_SIZE1];
    assign below2 = pktAddr < cfg_q[srat_pkg::IDX_SIZE2];
    assign below3 = pktAddr < cfg_q[srat_pkg::IDX_SIZE3];
    logic missNow;                         // Taken packet hits nothing
    assign missNow = accept && !below1 && !below2 && !below3;

    // Region one translation
    chk_region1_add: assert property (
        @(posedge clk) disable iff (!rstn)
        accept && below1 |=> locValid_q && locRegion_q == 2'h0
            && locAddr_q == $past(pktAddr)
               + $past(cfg_q[srat_pkg::IDX_OFFSET1]))
        else $error("Region one translation wrong");

    // Region two translation
    chk_region2_add: assert property (
        @(posedge clk) disable iff (!rstn)
        accept && !below1 && below2 |=> locRegion_q == 2'h1
            && locAddr_q == $past(pktAddr)
               + $past(cfg_q[srat_pkg::IDX_OFFSET2]))
        else $error("Region two translation wrong");

    // Region three translation
    chk_region3_add: assert property (
        @(posedge clk) disable iff (!rstn)
        accept && !below1 && !below2 && below3
            |=> locRegion_q == 2'h2
            && locAddr_q == $past(pktAddr)
               + $past(cfg_q[srat_pkg::IDX_OFFSET3]))
        else $error("Region three translation wrong");

    // Lower region wins an overlap
    chk_order_low: assert property (
        @(posedge clk) disable iff (!rstn)
        accept && below2 && !below1 && below3
            |=> locRegion_q == 2'h1)
        else $error("Region priority wrong");

    // Miss never issues, pulses drop once
    chk_miss_drop: assert property (
        @(posedge clk) disable iff (!rstn)
        missNow |=> !locValid_q && pktDrop
            ##1 pktDrop == $past(missNow))
        else $error("Unmatched packet issued");

    // Request holds until taken
    chk_req_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        locValid_q && !locReady |=> locValid_q && $stable(locAddr_q))
        else $error("Local request dropped early");

    // Low bits of the region two size field stay zero
    chk_low_bits: assert property (
        @(posedge clk) disable iff (!rstn)
        avsWrite && !wait_q && regIdx == srat_pkg::IDX_SIZE2
            |=> cfg_q[srat_pkg::IDX_SIZE2][1:0] == 2'h0
            && cfg_q[srat_pkg::IDX_SIZE2][31:2]
               == $past(avsWritedata[31:2]))
        else $error("Field write or low bits wrong");

    // Fields zero right after reset
    chk_reset_zero: assert property (
        @(posedge clk) disable iff (!rstn)
        !$past(rstn) |-> cfg_q[srat_pkg::IDX_OFFSET1] == 32'h0
            && cfg_q[srat_pkg::IDX_SIZE3] == 32'h0)
        else $error("Field not zero after reset");

    // Slave answers one cycle after a request
    chk_wait_once: assert property (
        @(posedge clk) disable iff (!rstn)
        (avsRead || avsWrite) && wait_q |=> !wait_q ##1 wait_q)
        else $error("Waitrequest timing wrong");

    // Unmatched count steps once per drop
    chk_drop_count: assert property (
        @(posedge clk) disable iff (!rstn)
        pktDrop |-> dropCnt_q == $past(dropCnt_q) + 16'h0001)
        else $error("Unmatched count wrong");

    // Packet side closed while a request is pending
    chk_ready_idle: assert property (
        @(posedge clk) disable iff (!rstn)
        locValid_q |-> !pktReady_q)
        else $error("Packet taken over pending request");

    // Main scenarios
    cov_region1: cover property (
        @(posedge clk) disable iff (!rstn) accept && below1);
    cov_region3: cover property (
        @(posedge clk) disable iff (!rstn)
        accept && !below1 && !below2 && below3);
    cov_miss: cover property (
        @(posedge clk) disable iff (!rstn) pktDrop);
    cov_stall: cover property (
        @(posedge clk) disable iff (!rstn)
        locValid_q && !locReady ##1 locValid_q && locReady);
endmodule

// *** verif/srat_peer.sv ***
// Remote peer model that offers inbound packet addresses
module srat_peer (
    input  wire logic        clk,
    input  wire logic        pktReady,
    output logic             pktValid,
    output logic      [31:0] pktAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Packet source
    // ------------------------------------------------------------
    // Idle at time zero
    initial begin
        pktValid = 1'b0;
        pktAddr  = 32'h0000_0000;
    end
    // Offer one address, hold it until the edge that takes it
    task automatic send(input logic [31:0] a);
        @(posedge clk);
        pktValid <= 1'b1;
        pktAddr  <= a;
        // Ready is judged at the rising edge that takes the packet
        do @(posedge clk); while (pktReady !== 1'b1);
        pktValid <= 1'b0;
        // Released lines show the inverse, never the old address
        pktAddr  <= ~a;
    endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the receive address translator
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;            // 250 MHz clock
    logic        rstn = 1'b0;           // Active low reset
    logic [4:0]  avsAddress = 5'h00;    // Register byte address
    logic        avsRead = 1'b0;        // Register read
    logic        avsWrite = 1'b0;       // Register write
    logic [31:0] avsWritedata = 32'h0;  // Register write data
    logic [31:0] avsReaddata;           // Register read data
    logic        avsWaitrequest;        // Register stall
    logic        pktValid;              // From peer
    logic [31:0] pktAddr;               // From peer
    logic        pktReady;              // To peer
    logic        locValid;              // Local request
    logic [31:0] locAddr;               // Local address
    logic [1:0]  locRegion;             // Region used
    logic        locReady = 1'b0;       // Local bus accepts
    logic        pktDrop;               // Unmatched pulse
    int          err_count = 0;         // Mismatches
    int          samples_checked = 0;   // Comparisons
    logic [31:0] rd;                    // Last read word
    always #2 clk = ~clk;
    // ------------------------------------------------------------
    // Design and peer
    // ------------------------------------------------------------
    srat_top i_dut (.clk(clk), .rstn(rstn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .pktValid(pktValid),
        .pktAddr(pktAddr), .pktReady(pktReady), .locValid(locValid),
        .locAddr(locAddr), .locRegion(locRegion), .locReady(locReady),
        .pktDrop(pktDrop));
    srat_peer i_peer (.clk(clk), .pktReady(pktReady),
        .pktValid(pktValid), .pktAddr(pktAddr));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One Avalon-MM access, held until waitrequest is seen low
    task automatic bus(input logic we, input logic [2:0] idx,
                       input logic [31:0] wd);
        @(posedge clk);
        avsAddress   <= {idx, 2'b00};
        avsWrite     <= we;
        avsRead      <= ~we;
        avsWritedata <= wd;
        // Waitrequest and read data are taken at the same rising edge
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    // Ends the run with the verdict
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every field reads zero after reset; status shows ready only
    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 3'(i), 32'h0);
            check(rd, 32'h0000_0000);
        end
        bus(1'b0, srat_pkg::IDX_STATUS, 32'h0);
        check(rd, 32'h0000_0001);
    endtask
    // All ones written, low two bits stay zero; unmapped stays zero
    task automatic t_lowbits();
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 3'(i), 32'hFFFF_FFFF);
            bus(1'b0, 3'(i), 32'h0);
            check(rd, 32'hFFFF_FFFC);
        end
        bus(1'b1, 3'h7, 32'hFFFF_FFFF);
        bus(1'b0, 3'h7, 32'h0);
        check(rd, 32'h0000_0000);
    endtask
    // Taken packet that hits: request stands through a stall
    task automatic pkt_hit(input logic [31:0] a, input logic [31:0] ea,
                           input logic [1:0] er);
        i_peer.send(a);
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            check(32'(locValid), 32'h1);
            check(locAddr, ea);
            check(32'(locRegion), 32'(er));
            check(32'(pktReady), 32'h0);
        end
        @(posedge clk);
        locReady <= 1'b1;
        @(posedge clk);
        locReady <= 1'b0;
        @(negedge clk);
        check(32'(locValid), 32'h0);
        check(32'(pktReady), 32'h1);
    endtask
    // Taken packet that misses: one drop pulse, no local request
    task automatic pkt_miss(input logic [31:0] a);
        i_peer.send(a);
        @(negedge clk);
        check(32'(pktDrop), 32'h1);
        check(32'(locValid), 32'h0);
        @(negedge clk);
        check(32'(pktDrop), 32'h0);
        check(32'(locValid), 32'h0);
    endtask
    // Three regions mapped, boundaries and priority walked
    task automatic t_map();
        logic [31:0] cfg [6];
        cfg = '{32'h100, 32'h1000, 32'h200, 32'h2000, 32'h400,
                32'hFFFF_F000};
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 3'(i), cfg[i]);
        end
        pkt_hit(32'h0000_00FC, 32'h0000_10FC, 2'h0);
        pkt_hit(32'h0000_0100, 32'h0000_2100, 2'h1);
        pkt_hit(32'h0000_01FC, 32'h0000_21FC, 2'h1);
        pkt_hit(32'h0000_0200, 32'hFFFF_F200, 2'h2);
        pkt_hit(32'h0000_03FC, 32'hFFFF_F3FC, 2'h2);
        pkt_miss(32'h0000_0400);
        bus(1'b0, srat_pkg::IDX_STATUS, 32'h0);
        check(rd, 32'h0001_0009);
    endtask
    // Mid-run reset clears every mapped field and the status again
    task automatic t_rerst();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    // Reset for two cycles, then the scenarios
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_lowbits();
        t_map();
        t_rerst();
        print_verdict();
    end
    // Cuts a hang short
    initial begin
        #20000;
        err_count++;
        print_verdict();
    end
endmodule
